// File: hdl/mqrs_read_port.sv
// four-queue store with pipelined read queue selection, null queue and bus matching
//
// Operation
// [R01] strobe high on a clock edge latches the read address as new read queue
// [R02] the selected queue stays in use until another selection is made
// [R03] controller waits at least 2 cycles between read queue selections
// [R04] next word of the new queue reaches the output register 2 edges after selection
// [R05] selecting edge reads old queue when enabled; next edge reads old queue regardless
// [R06] output enable high floats data bus; output register still loads
// [R07] switch pipeline holds old queue last word then new queue word, consecutive edges
// [R08] selecting an empty queue keeps last word and raises the invalid flag
// [R09] read address is 6 bits: 2 queue bits, null bit, 3 device bits
// [R10] device acts only when upper address bits equal its identity pins
// [R11] address bit 2 set selects the null queue, which is always empty
// [R12] after null selection old pipeline words drain, last word stays, flag invalid
// [R13] null queue exists on the read port only, in any mode
// [R14] empty flag bus strobe without read strobe picks device driving that bus
// [R15] full flag bus strobe without write strobe picks device via write bits 4..2
// [R16] width pins sampled at master reset choose x18 or x9 for each port
// [R17] width conversion orders bytes little endian
// [R18] full accounting counts in write port units
// [R19] valid and empty accounting counts in read port units
// [R20] all queues share the one input width and one output width
// [R21] read port can deliver a word on every edge, also during selection
// [R22] when reading stops at empty the last word falls through automatically
// [R23] after the last word, invalid flag rises on next edge with read enable low
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "mqrs_params.svh"
module mqrs_read_port #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // static straps
  input wire logic device_identity_bit0_i,
  input wire logic device_identity_bit1_i,
  input wire logic device_identity_bit2_i,
  input wire logic input_width_sel_i,
  input wire logic output_width_sel_i,
  // write port
  input wire logic [4:0] write_queue_addr_i,
  input wire logic write_addr_strobe_i,
  input wire logic almost_full_bus_strobe_i,
  input wire logic write_en_n_i,
  input wire mqrs_pkg::mqrs_word_t write_data_i,
  // read port
  input wire logic [5:0] read_queue_addr_i,
  input wire logic read_addr_strobe_i,
  input wire logic almost_empty_bus_strobe_i,
  input wire logic read_en_n_i,
  input wire logic output_enable_n_i,
  output logic [17:0] read_data_o,
  output logic read_data_oe_o,
  output logic output_valid_n_o,
  output logic output_valid_oe_o,
  // flag buses
  output logic [3:0] almost_empty_flag_bus_o,
  output logic almost_empty_flag_bus_oe_o,
  output logic [3:0] almost_full_flag_bus_o,
  output logic almost_full_flag_bus_oe_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import mqrs_pkg::*;

  localparam int NQ = 4;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // levels register packs one byte per queue
  if (DEPTH < 4 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two from 4 to 128");
  end

  typedef struct packed {
    logic [NQ-1:0][DEPTH-1:0][8:0] mem;
    logic [NQ-1:0][AW-1:0] wp;
    logic [NQ-1:0][AW-1:0] rp;
    logic [NQ-1:0][CW-1:0] cnt;
    logic iw;
    logic ow;
    logic [2:0] rq;
    logic [2:0] rpend;
    logic rd_dev;
    logic rpend_dev;
    mqrs_sw_t rsw;
    logic [1:0] wq;
    logic [1:0] wpend;
    logic wr_dev;
    logic wpend_dev;
    mqrs_sw_t wsw;
    mqrs_word_t out;
    logic ov_n;
    logic doe;
    logic ae_sel;
    logic af_sel;
    logic [NQ-1:0] ae_flags;
    logic [NQ-1:0] af_flags;
    logic ack;
    logic [31:0] rdat;
  } mqrs_state_t;

  mqrs_state_t s_r;
  mqrs_state_t s_nxt;

  logic [2:0] dev_id;
  logic [NQ-1:0] has_word;
  logic [NQ-1:0] q_full;
  logic cur_has;
  logic new_has;
  logic [1:0] rsrc;
  logic [1:0] wdst;
  logic wdev;
  logic [AW-1:0] rptr1;
  mqrs_word_t rd_word;
  logic bus_req;
  logic bus_wr;

  function automatic logic id_match(input logic [2:0] a, input logic [2:0] id);
    return a == id;
  endfunction

  assign dev_id = {device_identity_bit2_i, device_identity_bit1_i, device_identity_bit0_i};

  for (genvar g = 0; g < NQ; g++) begin : g_q
    // read side counts read-width units, write side write-width units
    assign has_word[g] = s_r.ow ? (s_r.cnt[g] != '0) : (s_r.cnt[g] >= CW'(2)); // [R19]
    assign q_full[g] = s_r.iw ? (s_r.cnt[g] == DEPTH_C) : (s_r.cnt[g] > DEPTH_C - CW'(2)); // [R18]
  end

  // null bit forces an empty view of the queue
  assign cur_has = s_r.rd_dev & ~s_r.rq[`MQRS_NULL_BIT] & has_word[s_r.rq[1:0]]; // [R11]
  assign new_has = s_r.rpend_dev & ~s_r.rpend[`MQRS_NULL_BIT] & has_word[s_r.rpend[1:0]]; // [R11]
  assign rsrc = (s_r.rsw == SW_NEW) ? s_r.rpend[1:0] : s_r.rq[1:0];
  assign wdst = (s_r.wsw == SW_NEW) ? s_r.wpend : s_r.wq;
  assign wdev = (s_r.wsw == SW_NEW) ? s_r.wpend_dev : s_r.wr_dev;
  assign rptr1 = s_r.rp[rsrc] + AW'(1);
  // low byte comes first out of the queue
  assign rd_word = s_r.ow ? {9'h000, s_r.mem[rsrc][s_r.rp[rsrc]]}
                          : {s_r.mem[rsrc][rptr1], s_r.mem[rsrc][s_r.rp[rsrc]]}; // [R17] [R20]
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & s_r.ack;

  always_comb begin
    logic pop;
    logic push;
    logic [NQ-1:0] flush;
    pop = 1'b0;
    push = 1'b0;
    flush = '0;
    s_nxt = s_r;

    // read queue selection, one edge is enough
    if (read_addr_strobe_i && s_r.rsw == SW_IDLE) begin
      s_nxt.rpend = read_queue_addr_i[2:0]; // [R01] [R09]
      s_nxt.rpend_dev = id_match(read_queue_addr_i[5:3], dev_id); // [R10]
      s_nxt.rsw = SW_OLD;
    end else if (!read_addr_strobe_i && almost_empty_bus_strobe_i) begin
      s_nxt.ae_sel = id_match(read_queue_addr_i[5:3], dev_id); // [R14]
    end

    unique case (s_r.rsw)
      SW_IDLE: begin
        // output register empty pulls the next word without read enable
        if (!read_en_n_i || s_r.ov_n) begin
          if (cur_has) begin
            pop = 1'b1; // [R21] [R22]
          end else if (!read_en_n_i) begin
            s_nxt.ov_n = 1'b1; // [R23]
          end
        end
      end
      SW_OLD: begin
        s_nxt.rsw = SW_NEW;
        if (cur_has) begin
          pop = 1'b1; // [R05] [R07]
        end else if (!read_en_n_i) begin
          s_nxt.ov_n = 1'b1;
        end
      end
      SW_NEW: begin
        s_nxt.rsw = SW_IDLE;
        s_nxt.rq = s_r.rpend; // [R02]
        s_nxt.rd_dev = s_r.rpend_dev;
        if (new_has) begin
          pop = 1'b1; // [R04] [R07]
        end else begin
          s_nxt.ov_n = 1'b1; // [R08] [R12] [R13]
        end
      end
      default: s_nxt.rsw = SW_IDLE;
    endcase

    if (pop) begin
      s_nxt.out = rd_word;
      s_nxt.ov_n = 1'b0;
    end
    // data enable does not gate the output register
    s_nxt.doe = s_nxt.rd_dev & ~output_enable_n_i; // [R06]

    // write queue selection mirrors the read side
    unique case (s_r.wsw)
      SW_IDLE: begin
        if (write_addr_strobe_i) begin
          s_nxt.wpend = write_queue_addr_i[1:0];
          s_nxt.wpend_dev = id_match(write_queue_addr_i[4:2], dev_id);
          s_nxt.wsw = SW_OLD;
        end
      end
      SW_OLD: s_nxt.wsw = SW_NEW;
      SW_NEW: begin
        s_nxt.wsw = SW_IDLE;
        s_nxt.wq = s_r.wpend;
        s_nxt.wr_dev = s_r.wpend_dev;
      end
      default: s_nxt.wsw = SW_IDLE;
    endcase
    if (!write_addr_strobe_i && almost_full_bus_strobe_i) begin
      s_nxt.af_sel = id_match(write_queue_addr_i[4:2], dev_id); // [R15]
    end
    push = wdev & ~write_en_n_i & ~q_full[wdst];

    // register bus: ack one cycle after request, write lands on the ack edge
    s_nxt.ack = bus_req & ~s_r.ack;
    s_nxt.rdat = 32'h00000000;
    if (bus_wr && wb_sel_i[0] && wb_adr_i == `MQRS_REG_CTRL) begin
      flush = wb_dat_i[`MQRS_CTRL_FLUSH_LSB +: NQ];
    end
    if (s_nxt.ack && !wb_we_i) begin
      unique case (wb_adr_i)
        `MQRS_REG_STAT: begin
          s_nxt.rdat[`MQRS_ST_RQ_LSB +: 3] = s_r.rq;
          s_nxt.rdat[`MQRS_ST_RDDEV_BIT] = s_r.rd_dev;
          s_nxt.rdat[`MQRS_ST_OVN_BIT] = s_r.ov_n;
          s_nxt.rdat[`MQRS_ST_IW_BIT] = s_r.iw;
          s_nxt.rdat[`MQRS_ST_OW_BIT] = s_r.ow;
          s_nxt.rdat[`MQRS_ST_HAS_LSB +: NQ] = has_word;
          s_nxt.rdat[`MQRS_ST_FULL_LSB +: NQ] = q_full;
          s_nxt.rdat[`MQRS_ST_WQ_LSB +: 2] = s_r.wq;
          s_nxt.rdat[`MQRS_ST_WRDEV_BIT] = s_r.wr_dev;
        end
        `MQRS_REG_LEVEL: begin
          for (int q = 0; q < NQ; q++) begin
            s_nxt.rdat[q*8 +: 8] = 8'(s_r.cnt[q]);
          end
        end
        default: s_nxt.rdat = 32'h00000000;
      endcase
    end

    // queue storage; a flush beats a same-cycle push or pop
    for (int q = 0; q < NQ; q++) begin
      if (push && wdst == 2'(q)) begin
        s_nxt.mem[q][s_r.wp[q]] = write_data_i[8:0]; // [R17]
        if (!s_r.iw) begin
          s_nxt.mem[q][s_r.wp[q] + AW'(1)] = write_data_i[17:9];
        end
        s_nxt.wp[q] = s_r.wp[q] + (s_r.iw ? AW'(1) : AW'(2));
      end
      if (pop && rsrc == 2'(q)) begin
        s_nxt.rp[q] = s_r.rp[q] + (s_r.ow ? AW'(1) : AW'(2));
      end
      s_nxt.cnt[q] = s_r.cnt[q]
                   + ((push && wdst == 2'(q)) ? (s_r.iw ? CW'(1) : CW'(2)) : CW'(0))
                   - ((pop && rsrc == 2'(q)) ? (s_r.ow ? CW'(1) : CW'(2)) : CW'(0)); // [R18] [R19]
      if (flush[q]) begin
        s_nxt.wp[q] = '0;
        s_nxt.rp[q] = '0;
        s_nxt.cnt[q] = '0;
      end
      s_nxt.ae_flags[q] = ~has_word[q];
      s_nxt.af_flags[q] = q_full[q];
    end

    if (rst_i) begin
      s_nxt = '0;
      s_nxt.iw = input_width_sel_i; // [R16]
      s_nxt.ow = output_width_sel_i; // [R16]
      s_nxt.ov_n = `MQRS_RST_OVN;
      s_nxt.out = `MQRS_RST_DATA;
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign read_data_o = s_r.out;
  assign read_data_oe_o = s_r.doe;
  assign output_valid_n_o = s_r.ov_n;
  assign output_valid_oe_o = s_r.rd_dev;
  assign almost_empty_flag_bus_o = s_r.ae_flags;
  assign almost_empty_flag_bus_oe_o = s_r.ae_sel;
  assign almost_full_flag_bus_o = s_r.af_flags;
  assign almost_full_flag_bus_oe_o = s_r.af_sel;
  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rsel;
    read_addr_strobe_i && s_r.rsw == SW_IDLE;
  endsequence
  sequence s_drain;
    s_r.rsw == SW_NEW ##1 s_r.rsw == SW_IDLE;
  endsequence

  property p_r01;
    s_rsel |-> ##2 (s_r.rsw == SW_NEW && s_r.rpend == $past(read_queue_addr_i[2:0], 2));
  endproperty
  a_r01: assert property (p_r01) else $error("read selection not latched"); // [R01]

  property p_r02;
    s_r.rsw == SW_IDLE && !read_addr_strobe_i |=> $stable(s_r.rq) && s_r.rsw == SW_IDLE;
  endproperty
  a_r02: assert property (p_r02) else $error("read queue changed without selection"); // [R02]

  property p_r04;
    s_rsel ##2 new_has |=> !output_valid_n_o && read_data_o == $past(rd_word);
  endproperty
  a_r04: assert property (p_r04) else $error("new queue word not out two edges after selection"); // [R04]

  property p_r05;
    s_r.rsw == SW_OLD && cur_has |=> !output_valid_n_o && read_data_o == $past(rd_word);
  endproperty
  a_r05: assert property (p_r05) else $error("forced read of previous queue missing"); // [R05]

  property p_r06;
    output_enable_n_i |=> !read_data_oe_o;
  endproperty
  a_r06: assert property (p_r06) else $error("data bus driven while disabled"); // [R06]

  property p_r07;
    s_r.rsw == SW_OLD |=> s_drain;
  endproperty
  a_r07: assert property (p_r07) else $error("switch pipeline did not step twice"); // [R07]

  property p_r08;
    s_r.rsw == SW_NEW && !new_has |=> output_valid_n_o && $stable(read_data_o);
  endproperty
  a_r08: assert property (p_r08) else $error("empty queue switch changed output"); // [R08]

  property p_r10;
    (s_rsel and !id_match(read_queue_addr_i[5:3], dev_id)) |-> ##3 !s_r.rd_dev;
  endproperty
  a_r10: assert property (p_r10) else $error("foreign device address selected this device"); // [R10]

  property p_r14;
    !read_addr_strobe_i && almost_empty_bus_strobe_i
      |=> almost_empty_flag_bus_oe_o == $past(id_match(read_queue_addr_i[5:3], dev_id));
  endproperty
  a_r14: assert property (p_r14) else $error("empty flag bus select wrong"); // [R14]

  property p_r15;
    !write_addr_strobe_i && almost_full_bus_strobe_i
      |=> almost_full_flag_bus_oe_o == $past(id_match(write_queue_addr_i[4:2], dev_id));
  endproperty
  a_r15: assert property (p_r15) else $error("full flag bus select wrong"); // [R15]

  property p_r22;
    s_r.rsw == SW_IDLE && output_valid_n_o && cur_has |=> !output_valid_n_o;
  endproperty
  a_r22: assert property (p_r22) else $error("word did not fall through"); // [R22]

  property p_r23;
    s_r.rsw == SW_IDLE && !read_en_n_i && !cur_has |=> output_valid_n_o;
  endproperty
  a_r23: assert property (p_r23) else $error("valid flag stayed low past last word"); // [R23]
endmodule

// File: hdl/mqrs_params.svh
// register offsets, field positions and reset values of the multiqueue read port
`ifndef MQRS_PARAMS_SVH
`define MQRS_PARAMS_SVH
`define MQRS_REG_CTRL 8'h00
`define MQRS_REG_STAT 8'h04
`define MQRS_REG_LEVEL 8'h08
`define MQRS_CTRL_FLUSH_LSB 0
`define MQRS_ST_RQ_LSB 0
`define MQRS_ST_RDDEV_BIT 3
`define MQRS_ST_OVN_BIT 4
`define MQRS_ST_IW_BIT 5
`define MQRS_ST_OW_BIT 6
`define MQRS_ST_HAS_LSB 8
`define MQRS_ST_FULL_LSB 12
`define MQRS_ST_WQ_LSB 16
`define MQRS_ST_WRDEV_BIT 18
`define MQRS_NULL_BIT 2
`define MQRS_RST_OVN 1'b1
`define MQRS_RST_DATA 18'h00000
`endif

// File: hdl/mqrs_pkg.sv
// types shared by the multiqueue read port
package mqrs_pkg;
  // queue switch phase, gray coded along idle -> old -> new; new -> idle flips both bits
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_OLD = 2'b01,
    SW_NEW = 2'b11
  } mqrs_sw_t;
  typedef logic [17:0] mqrs_word_t;
  typedef logic [8:0] mqrs_byte_t;
endpackage

// File: testbench/mqrs_ctl_model.sv
// system controller model driving read address, read strobe and empty flag strobe
`timescale 1ns/1ps
module mqrs_ctl_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench requests
  input wire logic sel_go_i,
  input wire logic flag_go_i,
  input wire logic [5:0] go_addr_i,
  // read address side of the port
  output logic [5:0] read_queue_addr_o,
  output logic read_addr_strobe_o,
  output logic almost_empty_bus_strobe_o
);
  logic [1:0] gap_r;
  logic take;
  assign take = sel_go_i && gap_r == 2'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_r <= 2'h0;
      read_queue_addr_o <= 6'h00;
      read_addr_strobe_o <= 1'b0;
      almost_empty_bus_strobe_o <= 1'b0;
    end else begin
      read_addr_strobe_o <= take;
      // hold off a request until three idle edges follow a selection
      gap_r <= take ? 2'h3 : (gap_r == 2'h0 ? 2'h0 : gap_r - 2'h1);
      almost_empty_bus_strobe_o <= flag_go_i && !sel_go_i;
      // unused address lines keep moving so a stale value never looks valid
      read_queue_addr_o <= (sel_go_i || flag_go_i) ? go_addr_i : ~read_queue_addr_o;
    end
  end
endmodule

// File: testbench/mqrs_read_port_tb.sv
// self-checking bench for the multiqueue read port
`timescale 1ns/1ps
`include "mqrs_params.svh"
module mqrs_read_port_tb;
  import mqrs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] wq_addr = 5'h00;
  logic wq_stb = 1'b0;
  logic af_stb = 1'b0;
  logic wen_n = 1'b1;
  mqrs_word_t wdata = 18'h00000;
  logic ren_n = 1'b1;
  logic oe_n = 1'b0;
  logic iw_sel = 1'b0;
  logic sel_go = 1'b0;
  logic flag_go = 1'b0;
  logic [5:0] go_addr = 6'h00;
  logic [5:0] rq_addr;
  logic rq_stb, ae_stb, rd_oe, vld_n, vld_oe, ae_oe, af_oe, ack;
  logic [17:0] rdata;
  logic [3:0] ae_bus, af_bus;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] wsel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, dat;
  int err_total = 0;
  int total_checks = 0;
  always #10 clk_i = ~clk_i;
  mqrs_ctl_model ctl_u (.clk_i(clk_i), .rst_i(rst_i), .sel_go_i(sel_go), .flag_go_i(flag_go),
    .go_addr_i(go_addr), .read_queue_addr_o(rq_addr), .read_addr_strobe_o(rq_stb),
    .almost_empty_bus_strobe_o(ae_stb));
  // identity 101 reads the same in either bit order
  mqrs_read_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .device_identity_bit0_i(1'b1),
    .device_identity_bit1_i(1'b0), .device_identity_bit2_i(1'b1), .input_width_sel_i(iw_sel),
    .output_width_sel_i(1'b0), .write_queue_addr_i(wq_addr), .write_addr_strobe_i(wq_stb),
    .almost_full_bus_strobe_i(af_stb), .write_en_n_i(wen_n), .write_data_i(wdata),
    .read_queue_addr_i(rq_addr), .read_addr_strobe_i(rq_stb), .almost_empty_bus_strobe_i(ae_stb),
    .read_en_n_i(ren_n), .output_enable_n_i(oe_n), .read_data_o(rdata), .read_data_oe_o(rd_oe),
    .output_valid_n_o(vld_n), .output_valid_oe_o(vld_oe), .almost_empty_flag_bus_o(ae_bus),
    .almost_empty_flag_bus_oe_o(ae_oe), .almost_full_flag_bus_o(af_bus),
    .almost_full_flag_bus_oe_o(af_oe), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    wsel <= w ? 4'hf : 4'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) chk("wb ack", 32'h1, 32'h0);
    dat = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // f selects the empty flag bus owner instead of a read queue
  task automatic sel(input logic f, input logic [5:0] a);
    @(posedge clk_i);
    sel_go <= ~f;
    flag_go <= f;
    go_addr <= a;
    @(posedge clk_i);
    sel_go <= 1'b0;
    flag_go <= 1'b0;
  endtask
  task automatic wr(input logic [1:0] q, input int n, input mqrs_word_t base);
    @(posedge clk_i);
    wq_addr <= {3'b101, q};
    wq_stb <= 1'b1;
    @(posedge clk_i);
    wq_stb <= 1'b0;
    // the selecting edge and the edge after it still write the old queue
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      wen_n <= 1'b0;
      wdata <= base + 18'(i);
    end
    @(posedge clk_i);
    wen_n <= 1'b1;
  endtask
  task automatic fsel(input logic [4:0] a);
    @(posedge clk_i);
    wq_addr <= a;
    af_stb <= 1'b1;
    @(posedge clk_i);
    af_stb <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `MQRS_REG_STAT, 32'h0);
    chk("status", 32'h10, dat);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, dat);
    $display("test reset done");
    wr(2'h0, 3, 18'h00011);
    wb(1'b0, `MQRS_REG_LEVEL, 32'h0);
    chk("level", 32'h6, dat);
    sel(1'b0, 6'h28);
    repeat (3) tick();
    chk("first word", 32'h11, 32'(rdata));
    chk("valid_n", 32'h0, 32'(vld_n));
    @(posedge clk_i);
    ren_n <= 1'b0;
    tick();
    chk("word2", 32'h12, 32'(rdata));
    tick();
    chk("word3", 32'h13, 32'(rdata));
    tick();
    chk("last kept", 32'h13, 32'(rdata));
    chk("valid_n last", 32'h1, 32'(vld_n));
    @(posedge clk_i);
    ren_n <= 1'b1;
    $display("test single queue done");
    wr(2'h1, 3, 18'h00101);
    wr(2'h2, 2, 18'h00201);
    sel(1'b0, 6'h29);
    repeat (3) tick();
    chk("q1 first", 32'h101, 32'(rdata));
    sel(1'b0, 6'h2a);
    ren_n <= 1'b0;
    @(posedge clk_i);
    ren_n <= 1'b1;
    #1;
    chk("select edge", 32'h102, 32'(rdata));
    tick();
    chk("forced read", 32'h103, 32'(rdata));
    tick();
    chk("q2 first", 32'h201, 32'(rdata));
    chk("q2 valid_n", 32'h0, 32'(vld_n));
    $display("test switch done");
    sel(1'b0, 6'h2f);
    ren_n <= 1'b0;
    @(posedge clk_i);
    ren_n <= 1'b1;
    repeat (2) tick();
    chk("null data", 32'h202, 32'(rdata));
    chk("null valid_n", 32'h1, 32'(vld_n));
    chk("valid oe", 32'h1, 32'(vld_oe));
    @(posedge clk_i);
    oe_n <= 1'b1;
    repeat (2) tick();
    chk("data oe off", 32'h0, 32'(rd_oe));
    @(posedge clk_i);
    oe_n <= 1'b0;
    repeat (2) tick();
    chk("data oe on", 32'h1, 32'(rd_oe));
    $display("test null done");
    wr(2'h3, 1, 18'h00301);
    sel(1'b1, 6'h28);
    repeat (3) tick();
    chk("empty bus oe", 32'h1, 32'(ae_oe));
    chk("empty bus", 32'h7, 32'(ae_bus));
    sel(1'b1, 6'h10);
    repeat (3) tick();
    chk("empty bus oe off", 32'h0, 32'(ae_oe));
    fsel(5'h16);
    repeat (2) tick();
    chk("full bus oe", 32'h1, 32'(af_oe));
    chk("full bus", 32'h0, 32'(af_bus));
    $display("test flag bus done");
    sel(1'b0, 6'h10);
    repeat (4) tick();
    chk("foreign valid oe", 32'h0, 32'(vld_oe));
    chk("foreign data oe", 32'h0, 32'(rd_oe));
    $display("test foreign done");
    wb(1'b0, `MQRS_REG_LEVEL, 32'h0);
    chk("level q3", 32'h02000000, dat);
    wb(1'b1, `MQRS_REG_CTRL, 32'h8);
    wb(1'b0, `MQRS_REG_LEVEL, 32'h0);
    chk("level flushed", 32'h0, dat);
    $display("test flush done");
    // second reset: x9 writes into an x18 read port
    @(posedge clk_i);
    rst_i <= 1'b1;
    iw_sel <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `MQRS_REG_STAT, 32'h0);
    chk("status x9 in", 32'h30, dat);
    wr(2'h0, 1, 18'h000a5);
    sel(1'b0, 6'h28);
    repeat (3) tick();
    chk("half word valid_n", 32'h1, 32'(vld_n));
    // second byte completes the word; first byte lands low
    wr(2'h0, 1, 18'h0015a);
    repeat (2) tick();
    chk("packed word", 32'h2b4a5, 32'(rdata));
    chk("packed valid_n", 32'h0, 32'(vld_n));
    wr(2'h1, 17, 18'h00000);
    wb(1'b0, `MQRS_REG_LEVEL, 32'h0);
    chk("level full", 32'h00001000, dat);
    fsel(5'h15);
    repeat (2) tick();
    chk("full bus q1", 32'h2, 32'(af_bus));
    $display("test bus matching done");
    give_verdict();
  end
endmodule
